// *** core/bnr_alarm_rx.sv ***
`timescale 1ns/10ps
module bnr_alarm_rx (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // bus pins; the clock line also clocks the bit capture
    input wire logic i_smb_scl,
    input wire logic i_smb_sda,
    output logic o_sda_out,
    output logic o_sda_oe_b,
    // internal emulation path
    input wire logic i_emu_valid,
    input wire logic [6:0] i_emu_addr,
    input wire logic [15:0] i_emu_data,
    // software side
    input wire logic i_alarm_clr,
    input wire logic [15:0] i_charger_capability_word,
    // alarm state
    output logic o_alarm_flag,
    output logic [7:0] o_alarm_addr,
    output logic [15:0] o_alarm_data,
    output bnr_pkg::bnr_src_t o_alarm_src,
    output logic o_charger_has_mgr,
    output logic o_sci,
    output logic o_gpe_ec
);
    import bnr_pkg::*;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic [PTR_W-1:0] wp_s1;
        logic [PTR_W-1:0] wp_s2;
        logic [PTR_W-1:0] rptr;
        bnr_frame_st_t fst;
        logic [3:0] bitcnt;
        logic [2:0] bytecnt;
        logic [7:0] shreg;
        logic [7:0] orig;
        logic [15:0] dat;
        logic ack_pend;
        logic ack_drv;
        logic ack_rel;
        logic alarm;
        logic [7:0] addr;
        logic [15:0] data;
        bnr_src_t src;
        logic has_mgr;
        logic sci;
        logic gpe;
    } bnr_sys_st_t;

    bnr_sys_st_t s_r;
    bnr_sys_st_t s_nxt;
    bnr_bits_if bits ();

    bnr_link_capture u_link (
        .i_link_clk(i_smb_scl),
        .i_smb_sda(i_smb_sda),
        .i_rst_b(i_rst_b),
        .bits(bits.link)
    );

    function automatic bnr_src_t bnr_decode_src(input logic [7:0] a, input logic mgr);
        if (a[7:1] == CHARGER_ADDR) begin
            return mgr ? BNR_SRC_CHG_MGR : BNR_SRC_CHARGER;
        end else if (a[7:1] == MANAGER_ADDR) begin
            return BNR_SRC_MANAGER;
        end
        return BNR_SRC_OTHER;
    endfunction : bnr_decode_src

    logic start_c;
    logic stop_c;
    logic avail_c;
    logic cap_bus_c;
    logic cap_c;
    logic [7:0] byte_c;
    logic [7:0] cap_addr_c;
    logic [15:0] cap_data_c;

    assign bits.rd_idx = s_r.rptr[IDX_W-1:0];

    always_comb begin
        s_nxt = s_r;
        cap_bus_c = 1'b0;
        byte_c = {s_r.shreg[6:0], bits.rd_bit};
        s_nxt.scl_s1 = i_smb_scl;
        s_nxt.scl_s2 = s_r.scl_s1;
        s_nxt.scl_d = s_r.scl_s2;
        s_nxt.sda_s1 = i_smb_sda;
        s_nxt.sda_s2 = s_r.sda_s1;
        s_nxt.sda_d = s_r.sda_s2;
        s_nxt.wp_s1 = bits.wptr_gray;
        s_nxt.wp_s2 = s_r.wp_s1;
        start_c = s_r.scl_s2 && s_r.scl_d && s_r.sda_d && !s_r.sda_s2;
        stop_c = s_r.scl_s2 && s_r.scl_d && !s_r.sda_d && s_r.sda_s2;
        avail_c = s_r.rptr != bnr_gray2bin(s_r.wp_s2);
        // the line may only change while the clock is low, or it would forge a start/stop
        if (s_r.ack_pend && !s_r.scl_s2) begin
            s_nxt.ack_pend = 1'b0;
            s_nxt.ack_drv = 1'b1;
        end
        if (s_r.ack_rel && !s_r.scl_s2) begin
            s_nxt.ack_rel = 1'b0;
            s_nxt.ack_drv = 1'b0;
        end
        if (start_c || stop_c) begin
            s_nxt.ack_pend = 1'b0;
            s_nxt.ack_drv = 1'b0;
            s_nxt.ack_rel = 1'b0;
        end
        case (s_r.fst)
            BNR_IDLE, BNR_SKIP: begin
                if (start_c) begin
                    s_nxt.fst = BNR_RECV;
                    s_nxt.rptr = bnr_gray2bin(s_r.wp_s2);
                    s_nxt.bitcnt = '0;
                    s_nxt.bytecnt = BYTECNT_RST;
                end else if (stop_c) begin
                    s_nxt.fst = BNR_IDLE;
                end
            end
            BNR_RECV: begin
                if (stop_c) begin
                    s_nxt.fst = BNR_IDLE;
                    cap_bus_c = (s_r.bytecnt == FRAME_BYTES);
                end else if (start_c) begin
                    s_nxt.rptr = bnr_gray2bin(s_r.wp_s2);
                    s_nxt.bitcnt = '0;
                    s_nxt.bytecnt = BYTECNT_RST;
                end else if (avail_c) begin
                    s_nxt.rptr = s_r.rptr + 1'b1;
                    if (s_r.bitcnt == ACK_SLOT_BIT) begin
                        s_nxt.bitcnt = '0;
                        s_nxt.ack_rel = s_r.ack_drv || s_r.ack_pend;
                    end else begin
                        s_nxt.shreg = byte_c;
                        s_nxt.bitcnt = s_r.bitcnt + 1'b1;
                    end
                    if (s_r.bitcnt == LAST_DATA_BIT) begin
                        if (s_r.bytecnt < OVERRUN_BYTES) begin
                            s_nxt.bytecnt = s_r.bytecnt + 1'b1;
                        end
                        s_nxt.ack_pend = (s_r.bytecnt < FRAME_BYTES);
                        case (s_r.bytecnt)
                            3'h0: begin
                                if (byte_c != HOST_WR_BYTE) begin
                                    s_nxt.fst = BNR_SKIP;
                                    s_nxt.ack_pend = 1'b0;
                                end
                            end
                            3'h1: s_nxt.orig = byte_c;
                            3'h2: s_nxt.dat[7:0] = byte_c;
                            3'h3: s_nxt.dat[15:8] = byte_c;
                            default: s_nxt.ack_pend = 1'b0;
                        endcase
                    end
                end
            end
            default: s_nxt.fst = BNR_IDLE;
        endcase
        // a bus capture wins over an emulated one in the same cycle
        cap_c = cap_bus_c || i_emu_valid;
        cap_addr_c = cap_bus_c ? s_r.orig : {i_emu_addr, 1'b0};
        cap_data_c = cap_bus_c ? s_r.dat : i_emu_data;
        s_nxt.has_mgr = i_charger_capability_word[CAP_MGR_BIT];
        // a new alarm in the clearing cycle is kept, never lost
        if (cap_c && (!s_r.alarm || i_alarm_clr)) begin
            s_nxt.alarm = 1'b1;
            s_nxt.addr = cap_addr_c;
            s_nxt.data = cap_data_c;
            s_nxt.src = bnr_decode_src(cap_addr_c, s_nxt.has_mgr);
        end else if (i_alarm_clr) begin
            s_nxt.alarm = 1'b0;
        end
        s_nxt.sci = s_nxt.alarm;
        s_nxt.gpe = s_nxt.alarm;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            s_r <= '0;
            s_r.scl_s1 <= 1'b1;
            s_r.scl_s2 <= 1'b1;
            s_r.scl_d <= 1'b1;
            s_r.sda_s1 <= 1'b1;
            s_r.sda_s2 <= 1'b1;
            s_r.sda_d <= 1'b1;
            s_r.fst <= BNR_IDLE;
            s_r.addr <= ALARM_ADDR_RST;
            s_r.data <= ALARM_DATA_RST;
            s_r.src <= BNR_SRC_OTHER;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe_b = !s_r.ack_drv;
    assign o_alarm_flag = s_r.alarm;
    assign o_alarm_addr = s_r.addr;
    assign o_alarm_data = s_r.data;
    assign o_alarm_src = s_r.src;
    assign o_charger_has_mgr = s_r.has_mgr;
    assign o_sci = s_r.sci;
    assign o_gpe_ec = s_r.gpe;
endmodule : bnr_alarm_rx

// *** core/bnr_bits_if.sv ***
`timescale 1ns/10ps
interface bnr_bits_if;
    import bnr_pkg::*;
    logic [PTR_W-1:0] wptr_gray;
    logic [IDX_W-1:0] rd_idx;
    logic rd_bit;
    modport link (output wptr_gray, output rd_bit, input rd_idx);
    modport sys (input wptr_gray, input rd_bit, output rd_idx);
endinterface : bnr_bits_if

// *** core/bnr_link_capture.sv ***
`timescale 1ns/10ps
module bnr_link_capture (
    // link side
    input wire logic i_link_clk,
    input wire logic i_smb_sda,
    input wire logic i_rst_b,
    // toward the system clock domain
    bnr_bits_if.link bits
);
    import bnr_pkg::*;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] wgray;
        logic [DEPTH-1:0] mem;
    } bnr_link_st_t;

    bnr_link_st_t s_r;
    bnr_link_st_t s_nxt;

    // every rising link clock edge out of reset stores one line bit; the clock stops between
    // frames, so framing is left entirely to the system side
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_s1 = i_rst_b;
        s_nxt.rst_s2 = s_r.rst_s1;
        if (!s_r.rst_s2) begin
            s_nxt.wptr = '0;
            s_nxt.wgray = '0;
        end else begin
            s_nxt.mem[s_r.wptr[IDX_W-1:0]] = i_smb_sda;
            s_nxt.wptr = s_r.wptr + 1'b1;
            s_nxt.wgray = bnr_bin2gray(s_nxt.wptr);
        end
    end

    always_ff @(posedge i_link_clk) begin
        s_r <= s_nxt;
    end

    assign bits.wptr_gray = s_r.wgray;
    // read only behind the synchronised pointer, so the entry is already stable
    assign bits.rd_bit = s_r.mem[bits.rd_idx];
endmodule : bnr_link_capture

// *** core/bnr_pkg.sv ***
package bnr_pkg;
    // bit-capture memory between the link clock and the system clock
    localparam int PTR_W = 5;
    localparam int IDX_W = 4;
    localparam int DEPTH = 16;
    // bus addresses, 7 bits
    localparam logic [6:0] HOST_SLAVE_ADDR = 7'h08;
    localparam logic [6:0] CHARGER_ADDR = 7'h09;
    localparam logic [6:0] MANAGER_ADDR = 7'h0A;
    // address byte of a write to the host slave interface
    localparam logic [7:0] HOST_WR_BYTE = {HOST_SLAVE_ADDR, 1'b0};
    // payload command codes per originator, for software reference
    localparam logic [7:0] CMD_CHARGER_STATE = 8'h13;
    localparam logic [7:0] CMD_CHARGER_CAP = 8'h11;
    localparam logic [7:0] CMD_CHG_SYS_STATE = 8'h21;
    localparam logic [7:0] CMD_SELECTOR_STATE = 8'h01;
    localparam logic [7:0] CMD_PACK_SYS_STATE = 8'h01;
    // capability word field: embedded manager or selector present
    localparam int CAP_MGR_BIT = 4;
    // frame layout
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT_BIT = 4'h8;
    localparam logic [2:0] FRAME_BYTES = 3'h4;
    localparam logic [2:0] OVERRUN_BYTES = 3'h5;
    // reset values
    localparam logic [7:0] ALARM_ADDR_RST = 8'h00;
    localparam logic [15:0] ALARM_DATA_RST = 16'h0000;
    localparam logic [2:0] BYTECNT_RST = 3'h0;

    typedef enum logic [2:0] {
        BNR_IDLE = 3'b001,
        BNR_RECV = 3'b010,
        BNR_SKIP = 3'b100
    } bnr_frame_st_t;

    typedef enum logic [1:0] {
        BNR_SRC_OTHER = 2'h0,
        BNR_SRC_CHARGER = 2'h1,
        BNR_SRC_CHG_MGR = 2'h2,
        BNR_SRC_MANAGER = 2'h3
    } bnr_src_t;

    function automatic logic [PTR_W-1:0] bnr_bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bnr_bin2gray

    function automatic logic [PTR_W-1:0] bnr_gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : bnr_gray2bin
endpackage : bnr_pkg

// *** verification/bnr_alarm_rx_chk.sv ***
`timescale 1ns/10ps
module bnr_alarm_rx_chk
    import bnr_pkg::*;
(
    // clock, reset and inputs
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_smb_scl,
    input wire logic i_emu_valid,
    input wire logic [6:0] i_emu_addr,
    input wire logic [15:0] i_emu_data,
    input wire logic i_alarm_clr,
    input wire logic [15:0] i_charger_capability_word,
    // outputs
    input wire logic o_sda_out,
    input wire logic o_sda_oe_b,
    input wire logic o_alarm_flag,
    input wire logic [7:0] o_alarm_addr,
    input wire logic [15:0] o_alarm_data,
    input wire bnr_src_t o_alarm_src,
    input wire logic o_charger_has_mgr,
    input wire logic o_sci,
    input wire logic o_gpe_ec
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // an emulated alarm is taken only while the flag is free or being cleared
    sequence s_take;
        i_emu_valid && (!o_alarm_flag || i_alarm_clr);
    endsequence
    sequence s_held;
        o_alarm_flag && !i_alarm_clr;
    endsequence
    a_emu_sets_flag: assert property (s_take |=> o_alarm_flag)
        else $error("emulated alarm did not set flag");
    a_addr_shifted: assert property (
        s_take |=> o_alarm_addr == {$past(i_emu_addr), 1'b0})
        else $error("alarm address not shifted by one");
    a_data_loaded: assert property (s_take |=> o_alarm_data == $past(i_emu_data))
        else $error("alarm data not loaded");
    a_manager_src: assert property (
        s_take and (i_emu_addr == MANAGER_ADDR) |=> o_alarm_src == BNR_SRC_MANAGER)
        else $error("manager source not decoded");
    a_sci_gpe_track: assert property (o_sci == o_alarm_flag && o_gpe_ec == o_alarm_flag)
        else $error("interrupt or event source differs from flag");
    a_capture_held: assert property (
        s_held |=> o_alarm_flag && $stable(o_alarm_addr) && $stable(o_alarm_data))
        else $error("captured alarm changed before clear");
    a_clear_drops: assert property (o_alarm_flag && i_alarm_clr && !i_emu_valid |=> !o_alarm_flag)
        else $error("clear did not drop flag");
    a_ack_scl_low: assert property ($fell(o_sda_oe_b) |-> !i_smb_scl && !o_sda_out)
        else $error("ack started outside clock low");
    a_ack_release: assert property ($fell(o_sda_oe_b) |-> ##[1:40] o_sda_oe_b)
        else $error("ack not released");
    a_cap_copy: assert property (
        $past(i_rst_b) |-> o_charger_has_mgr == $past(i_charger_capability_word[CAP_MGR_BIT]))
        else $error("capability bit copy wrong");
endmodule : bnr_alarm_rx_chk

// *** verification/bnr_dev_model.sv ***
`timescale 1ns/10ps
module bnr_dev_model (
    // bus wires
    output logic o_scl,
    output logic o_sda_drv,
    input wire logic i_sda
);
    logic lclk = 1'b0;
    initial forever #7.5 lclk = ~lclk;
    // lines idle high, clock stands still between frames
    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
        // idle clock pulses with data high, spanning the bench's reset release:
        // the capture pointer only sees reset on clock edges
        repeat (8) begin
            #40 o_scl = 1'b0;
            #40 o_scl = 1'b1;
        end
    end
    task half;
        repeat (24) @(posedge lclk);
    endtask : half
    // status change sent only as a write frame from the device
    task send(input logic [31:0] frame, output logic [3:0] nack);
        o_sda_drv = 1'b0;
        half;
        o_scl = 1'b0;
        for (int j = 3; j >= 0; j--) begin
            for (int k = 7; k >= -1; k--) begin
                // data moves one tick after the clock falls, never with it
                @(posedge lclk);
                o_sda_drv = (k < 0) ? 1'b1 : frame[8*j+k];
                half;
                o_scl = 1'b1;
                if (k < 0) nack[j] = i_sda;
                half;
                o_scl = 1'b0;
            end
        end
        @(posedge lclk);
        o_sda_drv = 1'b0;
        half;
        o_scl = 1'b1;
        half;
        o_sda_drv = 1'b1;
        half;
    endtask : send
endmodule : bnr_dev_model

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import bnr_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_emu_valid = 1'b0;
    logic [6:0] i_emu_addr = 7'h00;
    logic [15:0] i_emu_data = 16'h0000;
    logic i_alarm_clr = 1'b0;
    logic [15:0] i_charger_capability_word = 16'h0000;
    logic scl, dev_sda, sda, o_sda_out, o_sda_oe_b, o_alarm_flag, o_charger_has_mgr, o_sci, o_gpe_ec;
    logic [7:0] o_alarm_addr;
    logic [15:0] o_alarm_data;
    bnr_src_t o_alarm_src;
    logic [3:0] nack;
    int fail_count = 0;
    int n_compared = 0;
    localparam logic [6:0] AD [4] = '{CHARGER_ADDR, CHARGER_ADDR, MANAGER_ADDR, 7'h0B};
    localparam logic [15:0] CAP [4] = '{16'h0000, 16'h0010, 16'h0000, 16'h0000};
    localparam logic [1:0] SRC [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    // open drain data line with pull-up
    assign sda = dev_sda & (o_sda_oe_b | o_sda_out);
    bnr_alarm_rx u_bnr_alarm_rx (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_smb_scl(scl),
        .i_smb_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe_b(o_sda_oe_b),
        .i_emu_valid(i_emu_valid), .i_emu_addr(i_emu_addr), .i_emu_data(i_emu_data),
        .i_alarm_clr(i_alarm_clr), .i_charger_capability_word(i_charger_capability_word),
        .o_alarm_flag(o_alarm_flag), .o_alarm_addr(o_alarm_addr), .o_alarm_data(o_alarm_data),
        .o_alarm_src(o_alarm_src), .o_charger_has_mgr(o_charger_has_mgr), .o_sci(o_sci),
        .o_gpe_ec(o_gpe_ec));
    bnr_dev_model u_bnr_dev_model (.o_scl(scl), .o_sda_drv(dev_sda), .i_sda(sda));
    initial forever #25 i_sys_clk = ~i_sys_clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // capability set a cycle ahead, since its copy lags by one
    task emu(input logic [6:0] a, input logic [15:0] d, input logic [15:0] c);
        @(posedge i_sys_clk);
        i_charger_capability_word <= c;
        @(posedge i_sys_clk);
        i_emu_valid <= 1'b1;
        i_emu_addr <= a;
        i_emu_data <= d;
        @(posedge i_sys_clk);
        i_emu_valid <= 1'b0;
        #1;
    endtask : emu
    task clr;
        @(posedge i_sys_clk);
        i_alarm_clr <= 1'b1;
        @(posedge i_sys_clk);
        i_alarm_clr <= 1'b0;
        #1;
        chk(o_alarm_flag, 1'b0);
    endtask : clr
    task alarm(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
        chk(o_alarm_flag, 1'b1);
        chk({o_sci, o_gpe_ec}, 2'h3);
        chk(o_alarm_addr, a);
        chk(o_alarm_data, d);
        chk(o_alarm_src, s);
    endtask : alarm
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        chk({o_alarm_flag, o_sda_oe_b, o_alarm_addr}, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            emu(AD[i], 16'hA5C0 + 16'(i), CAP[i]);
            alarm({AD[i], 1'b0}, 16'hA5C0 + 16'(i), SRC[i]);
            chk(o_charger_has_mgr, CAP[i][CAP_MGR_BIT]);
            emu(7'h0B, 16'h0000, CAP[i]);
            alarm({AD[i], 1'b0}, 16'hA5C0 + 16'(i), SRC[i]);
            clr;
        end
        // clear and new alarm in one cycle: the new alarm wins
        emu(MANAGER_ADDR, 16'h1234, 16'h0000);
        @(posedge i_sys_clk);
        i_emu_valid <= 1'b1;
        i_alarm_clr <= 1'b1;
        i_emu_addr <= CHARGER_ADDR;
        i_emu_data <= 16'h5678;
        @(posedge i_sys_clk);
        i_emu_valid <= 1'b0;
        i_alarm_clr <= 1'b0;
        #1;
        alarm(8'h12, 16'h5678, 2'h1);
        clr;
        u_bnr_dev_model.send({HOST_WR_BYTE, 8'h12, 8'h34, 8'hC2}, nack);
        chk(nack, 4'h0);
        repeat (10) @(posedge i_sys_clk);
        #1;
        alarm(8'h12, 16'hC234, 2'h1);
        clr;
        u_bnr_dev_model.send({8'h16, 8'h14, 8'h01, 8'h00}, nack);
        chk(nack[3], 1'b1);
        repeat (10) @(posedge i_sys_clk);
        #1;
        chk(o_alarm_flag, 1'b0);
        end_sim;
    end
endmodule : testbench
bind bnr_alarm_rx bnr_alarm_rx_chk u_bnr_alarm_rx_chk (.*);
